//--- design/spsm_pkg.sv
// Serial port package: register map, field layouts, reset values, timing counts
//
// Notes on behaviour
// (RULE1) Mode 3 frames start, nine data bits and stop, paced by the external timer overflow.
// (RULE2) Mode 0 is half-duplex: data moves on the receive pin, the transmit pin carries clock.
// (RULE3) In mode 0 this port is always the clock master; the attached party only follows.
// (RULE4) A mode 0 transfer is exactly eight bits, least significant bit first, both ways.
// (RULE5) In mode 0 a write to the serial buffer starts transmission with no other trigger.
// (RULE6) In mode 0 the transmit-done flag sets at the end of the eighth bit time.
// (RULE7) Mode 0 reception starts only while receive enable is one and receive-done is zero.
// (RULE8) Receive-done sets one cycle after the eighth bit; no new reception until it clears.
// (RULE9) An enabled interrupt is raised whenever transmit-done or receive-done is set.
// (RULE10) The mode 0 shift clock runs at the system clock divided by twelve.
// (RULE11) In mode 0 the receive pin is an open-drain driver, needing an external pull-up.
// (RULE12) In nine-bit modes the ninth bit is one for an address byte, zero for data.
// (RULE13) With the address filter set, receive-done sets only when the ninth bit is one.
// (RULE14) With the address filter clear, every received byte sets receive-done.
// (RULE15) Mode 2 frames nine data bits with start and stop at system clock over 32 or 64.
// (RULE16) Four modes, one synchronous and three asynchronous, chosen in serial control.
// (RULE17) The received ninth bit is captured in a status bit as receive-done sets.
package spsm_pkg;

  // Register byte offsets
  localparam logic [3:0] SPSM_OFS_CTRL = 4'h0;
  localparam logic [3:0] SPSM_OFS_DATA = 4'h4;
  localparam logic [3:0] SPSM_OFS_STAT = 4'h8;
  localparam logic [3:0] SPSM_OFS_MASK = 4'hc;

  // Status and mask bit positions
  localparam int SPSM_BIT_RXD   = 0;
  localparam int SPSM_BIT_TXD   = 1;
  localparam int SPSM_BIT_NINTH = 2;
  localparam int SPSM_BIT_BUSY  = 3;

  // Operating modes
  localparam logic [1:0] SPSM_MODE_SYNC = 2'h0;
  localparam logic [1:0] SPSM_MODE_A8   = 2'h1;
  localparam logic [1:0] SPSM_MODE_A9F  = 2'h2;
  localparam logic [1:0] SPSM_MODE_A9T  = 2'h3;

  // Mode 0: twelve clocks per bit, clock low for the first half
  localparam logic [3:0] SPSM_M0_LAST = 4'hb;
  localparam logic [3:0] SPSM_M0_HIGH = 4'h6;
  // Async: sixteen ticks per bit, sampled mid-bit
  localparam logic [3:0] SPSM_OVS_LAST = 4'hf;
  localparam logic [3:0] SPSM_OVS_MID  = 4'h7;
  // Mode 2 tick prescale: 2 clocks (over 32) or 4 clocks (over 64)
  localparam logic [1:0] SPSM_PRE_FAST = 2'h1;
  localparam logic [1:0] SPSM_PRE_SLOW = 2'h3;
  // Last bit index: mode 0, ten-bit and eleven-bit frames
  localparam logic [3:0] SPSM_LAST_M0  = 4'h7;
  localparam logic [3:0] SPSM_LAST_A8  = 4'h9;
  localparam logic [3:0] SPSM_LAST_A9  = 4'ha;

  // Serial control register layout
  typedef struct packed {
    logic       baud_dbl;
    logic [1:0] mode;
    logic       addr_filter_bit;
    logic       rx_en;
    logic       tx_ninth;
  } spsm_ctrl_t;

  localparam spsm_ctrl_t SPSM_CTRL_RST = '{1'b0, 2'h0, 1'b0, 1'b0, 1'b0};
  localparam logic [1:0] SPSM_FLAG_RST = 2'h0;
  localparam logic [1:0] SPSM_MASK_RST = 2'h0;

endpackage : spsm_pkg

//--- design/spsm_serial_port.sv
// Serial port with synchronous shift mode and nine-bit address filter, AHB-Lite slave
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module spsm_serial_port
  import spsm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timer_ovf,
  output logic             txd,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_n,
  output logic             irq
);

  typedef enum logic [2:0] {
    A_IDLE = 3'b001,
    A_RUN  = 3'b010,
    A_FIN  = 3'b100
  } spsm_ast_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'b01,
    B_RUN  = 2'b10
  } spsm_bst_t;

  // Bus state
  logic        wr_r, wr_nxt;
  logic [3:0]  wa_r, wa_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        acc;
  // Software-visible state
  spsm_ctrl_t  ctrl_r, ctrl_nxt;
  logic [1:0]  flag_r, flag_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic [7:0]  rbuf_r, rbuf_nxt;
  logic        ninth_r, ninth_nxt;
  // Transmit / mode 0 engine
  spsm_ast_t   a_st_r, a_st_nxt;
  logic        a_rx_r, a_rx_nxt;
  logic [10:0] a_sh_r, a_sh_nxt;
  logic [3:0]  a_bit_r, a_bit_nxt;
  logic [3:0]  a_div_r, a_div_nxt;
  // Async receive engine
  spsm_bst_t   b_st_r, b_st_nxt;
  logic [8:0]  b_sh_r, b_sh_nxt;
  logic [3:0]  b_bit_r, b_bit_nxt;
  logic [3:0]  b_div_r, b_div_nxt;
  // Mode 2 prescaler
  logic [1:0]  pre_r, pre_nxt;
  // Cross-group strobes
  logic        mode0, tick, tx_go, set_tx, set_rx_a, set_rx_b;
  logic        b_ninth, a_step;
  logic [7:0]  b_data;
  logic [3:0]  a_last_div, a_last_bit, b_last_bit;

  assign mode0      = (ctrl_r.mode == SPSM_MODE_SYNC);
  assign acc        = hsel & htrans[1] & hready;
  assign tx_go      = wr_r & (wa_r == SPSM_OFS_DATA);
  assign hreadyout  = 1'b1; // Zero wait states, always OKAY
  assign hresp      = 1'b0;
  assign hrdata     = rd_r;

  // Bus slave: read data built in the address phase, writes land in the data phase
  always_comb begin
    wr_nxt = acc & hwrite;
    wa_nxt = acc ? haddr[3:0] : wa_r;
    rd_nxt = rd_r;
    if (acc & ~hwrite) begin
      if (haddr[3:0] == SPSM_OFS_CTRL) begin
        rd_nxt = {26'h0, ctrl_r};
      end else if (haddr[3:0] == SPSM_OFS_DATA) begin
        rd_nxt = {24'h0, rbuf_r};
      end else if (haddr[3:0] == SPSM_OFS_STAT) begin
        rd_nxt = {28'h0, a_st_r != A_IDLE, ninth_r, flag_r};
      end else if (haddr[3:0] == SPSM_OFS_MASK) begin
        rd_nxt = {30'h0, mask_r};
      end else begin
        rd_nxt = 32'h0; // Unmapped reads as zero
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= 1'b0;
      wa_r <= 4'h0;
      rd_r <= 32'h0;
    end else begin
      wr_r <= wr_nxt;
      wa_r <= wa_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Control, mask, sticky flags and receive buffer
  always_comb begin
    ctrl_nxt  = ctrl_r;
    mask_nxt  = mask_r;
    rbuf_nxt  = rbuf_r;
    ninth_nxt = ninth_r;
    flag_nxt  = flag_r;
    if (wr_r && wa_r == SPSM_OFS_CTRL) begin
      ctrl_nxt = hwdata[5:0]; // Mode select [RULE16]
    end
    if (wr_r && wa_r == SPSM_OFS_MASK) begin
      mask_nxt = hwdata[1:0];
    end
    if (wr_r && wa_r == SPSM_OFS_STAT) begin
      flag_nxt = flag_r & ~hwdata[1:0]; // Write one to clear
    end
    // Set wins over a clear in the same cycle [RULE9]
    if (set_tx) begin
      flag_nxt[SPSM_BIT_TXD] = 1'b1; // [RULE6]
    end
    if (set_rx_a) begin
      flag_nxt[SPSM_BIT_RXD] = 1'b1; // [RULE8]
      rbuf_nxt = a_sh_r[7:0];
    end
    if (set_rx_b) begin
      flag_nxt[SPSM_BIT_RXD] = 1'b1;
      rbuf_nxt  = b_data;
      ninth_nxt = b_ninth; // Captured with the flag edge [RULE17]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= SPSM_CTRL_RST;
      mask_r  <= SPSM_MASK_RST;
      flag_r  <= SPSM_FLAG_RST;
      rbuf_r  <= 8'h0;
      ninth_r <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      mask_r  <= mask_nxt;
      flag_r  <= flag_nxt;
      rbuf_r  <= rbuf_nxt;
      ninth_r <= ninth_nxt;
    end
  end

  // Level interrupt from unmasked sticky flags
  assign irq = |(flag_r & mask_r); // [RULE9]

  // Oversample tick: mode 2 from the prescaler, modes 1 and 3 from timer overflow
  always_comb begin
    pre_nxt = 2'h0;
    tick    = timer_ovf; // [RULE1]
    if (ctrl_r.mode == SPSM_MODE_A9F) begin
      tick    = (pre_r == (ctrl_r.baud_dbl ? SPSM_PRE_FAST : SPSM_PRE_SLOW)); // [RULE15]
      pre_nxt = tick ? 2'h0 : pre_r + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 2'h0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // Engine A limits: mode 0 steps every clock, async steps on ticks
  assign a_step     = mode0 | tick;
  assign a_last_div = mode0 ? SPSM_M0_LAST : SPSM_OVS_LAST; // [RULE10]
  assign a_last_bit = mode0 ? SPSM_LAST_M0 :
                      (ctrl_r.mode == SPSM_MODE_A8) ? SPSM_LAST_A8 : SPSM_LAST_A9;

  // Engine A: all transmission, plus mode 0 reception
  always_comb begin
    a_st_nxt  = a_st_r;
    a_rx_nxt  = a_rx_r;
    a_sh_nxt  = a_sh_r;
    a_bit_nxt = a_bit_r;
    a_div_nxt = a_div_r;
    set_tx    = 1'b0;
    set_rx_a  = 1'b0;
    case (a_st_r)
      A_IDLE: begin
        a_div_nxt = 4'h0;
        a_bit_nxt = 4'h0;
        if (tx_go) begin
          // Buffer write alone starts sending [RULE5]
          a_rx_nxt = 1'b0;
          a_st_nxt = A_RUN;
          if (mode0) begin
            a_sh_nxt = {3'b111, hwdata[7:0]};
          end else begin
            // Ninth bit marks address or data; ten-bit frames send stop [RULE12]
            a_sh_nxt = {1'b1, (ctrl_r.mode == SPSM_MODE_A8) | ctrl_r.tx_ninth,
                        hwdata[7:0], 1'b0};
          end
        end else if (mode0 && ctrl_r.rx_en && !flag_r[SPSM_BIT_RXD]) begin
          a_rx_nxt = 1'b1; // [RULE7]
          a_sh_nxt = 11'h0;
          a_st_nxt = A_RUN;
        end
      end
      A_RUN: begin
        if (a_step) begin
          a_div_nxt = a_div_r + 4'h1;
          // Sample on the rising shift clock edge, LSB arrives first [RULE4]
          if (a_rx_r && a_div_r == SPSM_M0_HIGH) begin
            a_sh_nxt = {3'b000, rxd_i, a_sh_r[7:1]};
          end
          if (a_div_r == a_last_div) begin
            a_div_nxt = 4'h0;
            a_bit_nxt = a_bit_r + 4'h1;
            if (!a_rx_r) begin
              a_sh_nxt = {1'b1, a_sh_r[10:1]};
            end
            if (a_bit_r == a_last_bit) begin
              set_tx   = ~a_rx_r; // End of the last bit time [RULE6]
              a_st_nxt = a_rx_r ? A_FIN : A_IDLE;
            end
          end
        end
      end
      A_FIN: begin
        set_rx_a = 1'b1; // One cycle after the eighth bit [RULE8]
        a_st_nxt = A_IDLE;
      end
      default: begin
        a_st_nxt = A_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_st_r  <= A_IDLE;
      a_rx_r  <= 1'b0;
      a_sh_r  <= 11'h7ff;
      a_bit_r <= 4'h0;
      a_div_r <= 4'h0;
    end else begin
      a_st_r  <= a_st_nxt;
      a_rx_r  <= a_rx_nxt;
      a_sh_r  <= a_sh_nxt;
      a_bit_r <= a_bit_nxt;
      a_div_r <= a_div_nxt;
    end
  end

  // Pins: mode 0 drives clock on txd and data open-drain on the receive pin
  always_comb begin
    txd      = 1'b1;
    rxd_oe_n = 1'b1;
    if (a_st_r == A_RUN) begin
      if (mode0) begin
        txd      = (a_div_r >= SPSM_M0_HIGH); // Master shift clock [RULE2] [RULE3]
        rxd_oe_n = a_rx_r | a_sh_r[0]; // Pull low only [RULE11]
      end else if (!a_rx_r) begin
        txd = a_sh_r[0];
      end
    end
  end
  assign rxd_o = 1'b0;

  // Engine B frame length and delivered fields
  assign b_last_bit = (ctrl_r.mode == SPSM_MODE_A8) ? SPSM_LAST_A8 : SPSM_LAST_A9;
  assign b_data     = (ctrl_r.mode == SPSM_MODE_A8) ? b_sh_r[8:1] : b_sh_r[7:0];
  assign b_ninth    = (ctrl_r.mode == SPSM_MODE_A8) ? rxd_i : b_sh_r[8];

  // Engine B: async reception with mid-bit sampling and address filter
  always_comb begin
    b_st_nxt  = b_st_r;
    b_sh_nxt  = b_sh_r;
    b_bit_nxt = b_bit_r;
    b_div_nxt = b_div_r;
    set_rx_b  = 1'b0;
    case (b_st_r)
      B_IDLE: begin
        b_div_nxt = 4'h0;
        b_bit_nxt = 4'h0;
        if (!mode0 && ctrl_r.rx_en && tick && !rxd_i) begin
          b_st_nxt = B_RUN;
        end
      end
      B_RUN: begin
        if (tick) begin
          b_div_nxt = b_div_r + 4'h1;
          if (b_div_r == SPSM_OVS_MID) begin
            b_bit_nxt = b_bit_r + 4'h1;
            if (b_bit_r == 4'h0) begin
              // A start glitch that is high mid-bit is dropped
              b_st_nxt = rxd_i ? B_IDLE : B_RUN;
            end else if (b_bit_r == b_last_bit) begin
              // Stop sample: filter on the ninth bit [RULE13] [RULE14]
              set_rx_b = !flag_r[SPSM_BIT_RXD] &&
                         (!ctrl_r.addr_filter_bit || b_ninth);
              b_st_nxt = B_IDLE;
            end else begin
              b_sh_nxt = {rxd_i, b_sh_r[8:1]};
            end
          end
        end
      end
      default: begin
        b_st_nxt = B_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      b_st_r  <= B_IDLE;
      b_sh_r  <= 9'h0;
      b_bit_r <= 4'h0;
      b_div_r <= 4'h0;
    end else begin
      b_st_r  <= b_st_nxt;
      b_sh_r  <= b_sh_nxt;
      b_bit_r <= b_bit_nxt;
      b_div_r <= b_div_nxt;
    end
  end

endmodule : spsm_serial_port

`default_nettype wire

//--- dv/spsm_serial_port_checker.sv
// Port assertions for the serial port
`timescale 1ns/10ps
`default_nettype none
module spsm_serial_port_checker
  import spsm_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        txd,
  input wire logic        rxd_o,
  input wire logic        rxd_oe_n,
  input wire logic        irq
);
  logic       ctl_wr_r;
  logic [1:0] mode_r;
  wire        m0 = (mode_r == SPSM_MODE_SYNC);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Mode shadow, so shift checks skip async frames
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_wr_r <= 1'h0;
      mode_r   <= SPSM_CTRL_RST.mode;
    end else begin
      ctl_wr_r <= hready ? (hsel && htrans[1] && hwrite && haddr == 32'h0) : ctl_wr_r;
      mode_r   <= (ctl_wr_r && hready) ? hwdata[4:3] : mode_r;
    end
  end
  a_clk_low: assert property (m0 && $fell(txd) |-> (!txd)[*6] ##1 txd)
    else $error("shift clock low half wrong");
  a_clk_high: assert property (m0 && $rose(txd) |-> txd[*6])
    else $error("shift clock high half short");
  a_bit_period: assert property (m0 && $fell(txd) |-> ##12 ($fell(txd) || txd))
    else $error("shift bit not twelve cycles");
  a_data_edge: assert property ($fell(rxd_oe_n) |-> $fell(txd))
    else $error("data pin moved off the bit start");
  a_data_hold: assert property (m0 && !txd && !$fell(txd) |-> $stable(rxd_oe_n))
    else $error("data pin moved inside a bit");
  a_open_drain: assert property (!rxd_o && (m0 || rxd_oe_n))
    else $error("receive pin driven high or outside mode 0");
  a_irq_clear: assert property ($fell(irq) |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("interrupt dropped without a write");
  a_reset_idle: assert property ($rose(rst_n) |-> txd && rxd_oe_n && !irq)
    else $error("pins not idle after reset");
endmodule : spsm_serial_port_checker

bind spsm_serial_port spsm_serial_port_checker u_chk (.mclk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .txd, .rxd_o, .rxd_oe_n, .irq);
`default_nettype wire

//--- dv/spsm_partner.sv
// Shift-register partner on the open-drain receive line
`timescale 1ns/10ps
`default_nettype none
module spsm_partner (
  input  wire logic       txd,
  input  wire logic       rxd_o,
  input  wire logic       rxd_oe_n,
  input  wire logic       arm,
  input  wire logic       loop,
  input  wire logic [7:0] tx_byte,
  output logic            rxd_i,
  output logic [7:0]      got,
  output var int          nbits
);
  int   cur = 8;
  logic clk_seen = 1'b0;
  // Wire-and with pull-up; released line reads high
  wire pull = (!rxd_oe_n && !rxd_o) || (arm && cur inside {[0:7]} && !tx_byte[cur[2:0]]);
  assign rxd_i = !pull && (!loop || txd);
  initial nbits = 0;
  // New byte restarts at bit zero
  always @(posedge arm) cur = -1;
  // Only follows the master clock, next bit on its fall
  always @(negedge txd) begin
    clk_seen = 1'b1;
    if (arm && !loop) cur++;
  end
  // Capture on the rise, LSB first; the settle of txd at start is no clock edge
  always @(posedge txd) begin
    if (!loop && clk_seen) begin
      got = {rxd_i, got[7:1]};
      nbits++;
    end
  end
endmodule : spsm_partner
`default_nettype wire

//--- dv/tb_serial_port_sync_multiproc.sv
// Self-checking bench: shift mode, interrupts, address filter
`timescale 1ns/10ps
`default_nettype none
module tb_serial_port_sync_multiproc;
  import spsm_pkg::*;
  logic        mclk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, timer_ovf = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp, txd, rxd_i, rxd_o, rxd_oe_n, irq;
  logic        arm = 1'h0, loop = 1'h0;
  logic [7:0]  pbyte = 8'h0, got;
  int          nbits, tk = 0, n_mismatch = 0, cmp_count = 0;
  assign hready = hreadyout;
  spsm_serial_port dut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .timer_ovf, .txd, .rxd_i, .rxd_o, .rxd_oe_n, .irq);
  spsm_partner peer (.txd, .rxd_o, .rxd_oe_n, .arm, .loop, .tx_byte(pbyte), .rxd_i, .got, .nbits);
  initial forever #12.5 mclk = ~mclk;
  // Baud tick, one in four clocks, keeps async frames short
  always @(posedge mclk) begin
    tk <= tk + 1;
    timer_ovf <= (tk % 4) == 3;
  end
  task chk(input string nm, input logic [31:0] exp, v);
    cmp_count++;
    if (v !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, v);
    end
  endtask : chk
  // Single AHB transfer; holds each phase until hready
  task bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'h1);
    q = hrdata;
  endtask : bus
  task wait_irq(input logic lvl, input int lim, output int n);
    for (n = 0; irq !== lvl && n < lim; n++) @(posedge mclk);
    if (n >= lim) chk("irq wait", lvl, irq);
  endtask : wait_irq
  task t_regs;
    logic [31:0] q;
    for (int a = 0; a <= 16; a += 4) begin
      if (a != 4) bus(1'h0, a, 32'h0, q);
      if (a != 4) chk("reset value", 32'h0, q);
    end
    chk("okay response", 32'h0, hresp);
    bus(1'h1, 32'h0, 32'h3f, q);
    bus(1'h0, 32'h0, 32'h0, q);
    chk("ctrl readback", 32'h3f, q);
    bus(1'h1, 32'h0, 32'h0, q);
  endtask : t_regs
  task t_tx;
    logic [31:0] q;
    int n;
    bus(1'h1, SPSM_OFS_MASK, 32'h2, q);
    bus(1'h1, SPSM_OFS_DATA, 32'ha5, q);
    bus(1'h1, SPSM_OFS_DATA, 32'h3c, q);
    wait_irq(1'h1, 200, n);
    chk("tx done time", 1'h1, n >= 93 && n <= 97);
    chk("tx byte", 8'ha5, got);
    bus(1'h0, SPSM_OFS_STAT, 32'h0, q);
    chk("tx flag", 2'h2, q[1:0]);
    bus(1'h1, SPSM_OFS_STAT, 32'h2, q);
    wait_irq(1'h0, 4, n);
    // Masked event must stay quiet until the mask opens
    bus(1'h1, SPSM_OFS_MASK, 32'h0, q);
    bus(1'h1, SPSM_OFS_DATA, 32'h5a, q);
    bus(1'h0, SPSM_OFS_STAT, 32'h0, q);
    chk("busy", 32'h8, q);
    repeat (120) @(posedge mclk);
    chk("masked irq", 1'h0, irq);
    chk("second byte", 8'h5a, got);
    chk("bit count", 16, nbits);
    bus(1'h1, SPSM_OFS_MASK, 32'h2, q);
    wait_irq(1'h1, 4, n);
    bus(1'h1, SPSM_OFS_STAT, 32'h2, q);
    wait_irq(1'h0, 4, n);
  endtask : t_tx
  task t_rx;
    logic [31:0] q;
    int n;
    pbyte <= 8'h6b;
    arm <= 1'h1;
    bus(1'h1, SPSM_OFS_MASK, 32'h1, q);
    bus(1'h1, SPSM_OFS_CTRL, 32'h2, q);
    wait_irq(1'h1, 200, n);
    bus(1'h0, SPSM_OFS_DATA, 32'h0, q);
    chk("rx byte", 8'h6b, q[7:0]);
    repeat (40) @(posedge mclk);
    chk("rx halted", 24, nbits);
    arm <= 1'h0;
    bus(1'h1, SPSM_OFS_CTRL, 32'h0, q);
    bus(1'h1, SPSM_OFS_STAT, 32'h1, q);
    repeat (40) @(posedge mclk);
    chk("rx disabled", 24, nbits);
    chk("rx irq clear", 1'h0, irq);
  endtask : t_rx
  // Loopback frames: {mode, filter, ninth, delivered}
  task t_async;
    logic [31:0] q;
    logic [4:0]  cs[5];
    int          n;
    cs = '{5'h14, 5'h17, 5'h11, 5'h1f, 5'h09};
    loop <= 1'h1;
    bus(1'h1, SPSM_OFS_MASK, 32'h2, q);
    for (int i = 0; i < 5; i++) begin
      bus(1'h1, SPSM_OFS_CTRL, {26'h0, 1'(i), cs[i][4:2], 1'h1, cs[i][1]}, q);
      bus(1'h1, SPSM_OFS_DATA, 32'h30 + i, q);
      wait_irq(1'h1, 2000, n);
      bus(1'h0, SPSM_OFS_STAT, 32'h0, q);
      chk("rx flag", cs[i][0], q[0]);
      if (cs[i][0]) chk("ninth bit", cs[i][4:3] == 2'h1 || cs[i][1], q[2]);
      bus(1'h0, SPSM_OFS_DATA, 32'h0, q);
      if (cs[i][0]) chk("async byte", 32'h30 + i, q);
      bus(1'h1, SPSM_OFS_STAT, 32'h3, q);
      wait_irq(1'h0, 4, n);
    end
    loop <= 1'h0;
  endtask : t_async
  task conclude;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    t_regs();
    t_tx();
    t_rx();
    t_async();
    conclude();
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end
endmodule : tb_serial_port_sync_multiproc
`default_nettype wire
